// ==== rtl/dac_bus_if.sv ====
// Interface joining the host writer and the converter card.
`timescale 1ns/1ps
interface dac_bus_if;
    logic       wr_stb;     // One-cycle write strobe.
    logic       wide;       // Sixteen-bit write when high.
    logic [3:0] addr;       // Port offset relative to the card base.
    logic [15:0] wdata;     // Write data, low byte in bits 7..0.
    logic       twos_sel;   // Card reports two's complement coding.
    modport card (input wr_stb, wide, addr, wdata, output twos_sel);
    modport host (output wr_stb, wide, addr, wdata, input twos_sel);
endinterface

// ==== rtl/dac_card.sv ====
// Converter card end: port decode, two channels and coding select.
// Functional notes
// RULE_01: Code split into low byte and nibble.
// RULE_02: Low byte write only loads holding register.
// RULE_03: High byte write updates all twelve bits.
// RULE_04: Host writes low byte before high byte.
// RULE_05: Code right justified in 16-bit word.
// RULE_06: Ports at offsets 8, 9, A, B.
// RULE_07: High byte bits 7..4 ignored, sent zero.
// RULE_08: Host codes 0..4095 or signed codes.
// RULE_09: Jumper sets format for all data paths.
// RULE_10: Two's complement needs bipolar range.
// RULE_11: Sixteen-bit write updates channel completely.
// RULE_12: Two independent double-buffered channels.
// RULE_13: Offset binary unless jumper installed.
// RULE_14: Reset clears holding and output codes.
`timescale 1ns/1ps
module dac_card
    import dac_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rstn,
    // Host side.
    dac_bus_if.card          bus,
    // Board jumper, a pin.
    input  wire logic        twos_complement_select_jumper,
    // Converter codes and the coding in force.
    output logic [11:0]      analog_out_ch0,
    output logic [11:0]      analog_out_ch1,
    output logic             twos_format
);
    logic       jmp_s1_r;
    logic       jmp_s2_r;
    logic [1:0] ld_low;
    logic [1:0] ld_high;

    // =====================================================================
    // Jumper synchroniser
    // =====================================================================
    // Two flops; offset binary is the coding until the jumper is seen.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            jmp_s1_r <= 1'b0;
            jmp_s2_r <= 1'b0;
        end else begin
            jmp_s1_r <= twos_complement_select_jumper;
            jmp_s2_r <= jmp_s1_r;
        end
    end

    // One flag drives the twos_format pin and the twos_sel bit read back by the host.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            twos_format <= 1'b0;                            // [RULE_13]
        end else begin
            twos_format <= jmp_s2_r;                        // [RULE_09] [RULE_13]
        end
    end
    assign bus.twos_sel = twos_format;

    // =====================================================================
    // Port decode
    // =====================================================================
    // A wide write at a low port loads low and high together in one strobe.
    always_comb begin
        ld_low  = 2'b00;
        ld_high = 2'b00;
        if (bus.wr_stb) begin
            case (bus.addr)                                 // [RULE_06]
                OFS_CH0_LOW: begin
                    ld_low[0]  = 1'b1;
                    ld_high[0] = bus.wide;                  // [RULE_11]
                end
                OFS_CH0_HIGH: ld_high[0] = 1'b1;
                OFS_CH1_LOW: begin
                    ld_low[1]  = 1'b1;
                    ld_high[1] = bus.wide;                  // [RULE_11]
                end
                OFS_CH1_HIGH: ld_high[1] = 1'b1;
                default: begin
                    ld_low  = 2'b00;
                    ld_high = 2'b00;
                end
            endcase
        end
    end

    // =====================================================================
    // Channels
    // =====================================================================
    logic [11:0] codes [2];
    logic [7:0]  hi_src [2];
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch              // [RULE_12]
            // Wide writes carry the nibble in bits 11..8.
            assign hi_src[g] = bus.wide ? bus.wdata[15:8]
                                        : bus.wdata[7:0];   // [RULE_01] [RULE_05]
            dac_channel u_ch (
                .clk       (clk),
                .rstn      (rstn),
                .load_low  (ld_low[g]),
                .load_high (ld_high[g]),
                .low_byte  (bus.wdata[7:0]),
                .high_byte (hi_src[g]),
                .code      (codes[g])
            );
        end
    endgenerate
    assign analog_out_ch0 = codes[0];
    assign analog_out_ch1 = codes[1];
endmodule

// ==== rtl/dac_channel.sv ====
// One double-buffered converter channel.
`timescale 1ns/1ps
module dac_channel
    import dac_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rstn,
    // Byte loads.
    input  wire logic        load_low,
    input  wire logic        load_high,
    input  wire logic [7:0]  low_byte,
    input  wire logic [7:0]  high_byte,
    // Converter code.
    output logic [11:0]      code
);
    logic [7:0] hold_r;

    // =====================================================================
    // Holding register and broadside update
    // =====================================================================
    // A low byte only fills the holding register.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            hold_r <= LOW_RESET;                            // [RULE_14]
        end else if (load_low) begin
            hold_r <= low_byte;                             // [RULE_02]
        end
    end

    // A high byte merges with the held bits, upper nibble dropped.
    // A wide write loads both halves at once, so the fresh low byte
    // bypasses the holding register instead of using its stale value.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            code <= CODE_RESET;                             // [RULE_14]
        end else if (load_high) begin
            code <= {high_byte[HIGH_FLD_W-1:0],
                     load_low ? low_byte : hold_r};         // [RULE_03] [RULE_07]
        end
    end
endmodule

// ==== rtl/dac_host.sv ====
// Host end: APB slave registers driving byte or word writes to the card.
`timescale 1ns/1ps
module dac_host
    import dac_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rstn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Card side.
    dac_bus_if.host          bus
);
    typedef enum logic [1:0] {IDLE = 2'b00, LOW = 2'b01, HIGH = 2'b11}
        wst_e;
    wst_e        st_r;
    logic        ch_r;
    logic [11:0] val_r;
    logic [1:0]  ctrl_r;
    logic        acc;
    logic        go;

    assign acc     = psel && penable;
    assign pready  = 1'b1;
    assign go      = acc && pwrite && (st_r == IDLE) &&
                     (paddr == REG_CH0_CODE || paddr == REG_CH1_CODE);
    assign pslverr = acc && !(paddr == REG_CH0_CODE ||
                     paddr == REG_CH1_CODE || paddr == REG_CTRL ||
                     paddr == REG_STATUS);

    // =====================================================================
    // Control register
    // =====================================================================
    // Wide mode and the bipolar range flag that two's complement needs.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_r <= 2'b00;
        end else if (acc && pwrite && paddr == REG_CTRL) begin
            ctrl_r <= pwdata[1:0];                          // [RULE_10]
        end
    end

    // Read data.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                REG_CTRL:   prdata <= {30'h0, ctrl_r};
                REG_STATUS: prdata <= {29'h0, ctrl_r[CTRL_BIPOLAR],
                                       bus.twos_sel, st_r != IDLE};
                default:    prdata <= 32'h0000_0000;
            endcase
        end
    end

    // =====================================================================
    // Write sequencer
    // =====================================================================
    // Low byte always goes first, then the high byte unless wide mode sends one word.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_r  <= IDLE;
            ch_r  <= 1'b0;
            val_r <= 12'h000;
        end else begin
            case (st_r)
                IDLE: if (go) begin
                    ch_r  <= paddr[2];
                    val_r <= pwdata[11:0];                  // [RULE_08]
                    st_r  <= LOW;
                end
                LOW:  st_r <= ctrl_r[CTRL_WIDE] ? IDLE : HIGH;
                HIGH: st_r <= IDLE;
                default: st_r <= IDLE;
            endcase
        end
    end

    // Card strobes, registered.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            bus.wr_stb <= 1'b0;
            bus.wide   <= 1'b0;
            bus.addr   <= 4'h0;
            bus.wdata  <= 16'h0000;
        end else begin
            bus.wr_stb <= (st_r == LOW) || (st_r == HIGH);
            bus.wide   <= (st_r == LOW) && ctrl_r[CTRL_WIDE]; // [RULE_11]
            bus.addr   <= ch_r ? ((st_r == HIGH) ? OFS_CH1_HIGH : OFS_CH1_LOW)
                               : ((st_r == HIGH) ? OFS_CH0_HIGH : OFS_CH0_LOW);
            if (st_r == HIGH) begin
                bus.wdata <= {8'h00, 4'h0, val_r[11:8]};    // [RULE_07] [RULE_04]
            end else begin
                bus.wdata <= {4'h0, val_r};                 // [RULE_01] [RULE_05]
            end
        end
    end
endmodule

// ==== rtl/dac_pkg.sv ====
// Package of shared constants for the dual converter write path.
package dac_pkg;
    // =====================================================================
    // Port map and field layout
    // =====================================================================
    localparam int          CODE_W       = 12;
    localparam int          WORD_W       = 16;
    localparam logic [3:0]  OFS_CH0_LOW  = 4'h8;
    localparam logic [3:0]  OFS_CH0_HIGH = 4'h9;
    localparam logic [3:0]  OFS_CH1_LOW  = 4'hA;
    localparam logic [3:0]  OFS_CH1_HIGH = 4'hB;
    localparam int          HIGH_FLD_W   = 4;
    localparam logic [11:0] CODE_RESET   = 12'h000;
    localparam logic [7:0]  LOW_RESET    = 8'h00;
    // =====================================================================
    // Host register map on APB (byte addresses)
    // =====================================================================
    localparam logic [7:0]  REG_CH0_CODE = 8'h00;
    localparam logic [7:0]  REG_CH1_CODE = 8'h04;
    localparam logic [7:0]  REG_CTRL     = 8'h08;
    localparam logic [7:0]  REG_STATUS   = 8'h0C;
    localparam int          CTRL_WIDE    = 0;
    localparam int          CTRL_BIPOLAR = 1;
    localparam int          STAT_BUSY    = 0;
    localparam int          STAT_TWOS    = 1;
    localparam int          STAT_RANGE   = 2;
endpackage

// ==== tb/dac_link_chk.sv ====
// Checker of the host-to-card link and the converter codes.
`timescale 1ns/1ps
module dac_link_chk (
    // Clock, reset and link.
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        wr_stb,
    input wire logic        wide,
    input wire logic [3:0]  addr,
    input wire logic [15:0] wdata,
    // Card pins.
    input wire logic        twos_complement_select_jumper,
    input wire logic [11:0] analog_out_ch0,
    input wire logic [11:0] analog_out_ch1,
    input wire logic        twos_format
);
    logic [7:0] held0_r;
    logic [7:0] held1_r;
    // Mirror of the low bytes held by each channel.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            held0_r <= 8'h00;
            held1_r <= 8'h00;
        end else if (wr_stb) begin
            if (addr == 4'h8) held0_r <= wdata[7:0];
            if (addr == 4'hA) held1_r <= wdata[7:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_low_no_update:
    assert property (wr_stb && !wide && addr == 4'h8 |=>
        $stable(analog_out_ch0)) else $error("Low byte moved code");
    a_merge_ch0:
    assert property (wr_stb && !wide && addr == 4'h9 |=> analog_out_ch0
        == {$past(wdata[3:0]), $past(held0_r)}) else $error("Bad ch0");
    a_merge_ch1:
    assert property (wr_stb && !wide && addr == 4'hB |=> analog_out_ch1
        == {$past(wdata[3:0]), $past(held1_r)}) else $error("Bad ch1");
    a_wide_ch0:
    assert property (wr_stb && wide && addr == 4'h8 |=> analog_out_ch0
        == $past(wdata[11:0])) else $error("Bad wide write");
    a_ch1_kept:
    assert property (wr_stb && addr[3:1] == 3'b100 |=>
        $stable(analog_out_ch1)) else $error("Ch1 disturbed");
    a_ch0_kept:
    assert property (wr_stb && addr[3:1] == 3'b101 |=>
        $stable(analog_out_ch0)) else $error("Ch0 disturbed");
    a_idle_kept:
    assert property (!wr_stb |=> $stable(analog_out_ch0) &&
        $stable(analog_out_ch1)) else $error("Code moved when idle");
    a_twos_follow:
    assert property ($rose(twos_complement_select_jumper) |-> ##[1:4]
        twos_format) else $error("Coding did not follow jumper");
endmodule

// ==== tb/dual_dac_double_buffer_writer_tb.sv ====
// Testbench joining the host end and the card end.
`timescale 1ns/1ps
module dual_dac_double_buffer_writer_tb;
    import dac_pkg::*;
    logic        clk, rstn, psel, penable, pwrite, pready, pslverr;
    logic        jmp, twos_format, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] out0, out1;
    logic [11:0] code_exp[2];
    logic [20:0] stb_q[$];
    int          n_mismatch, checks_done;
    dac_bus_if bus ();
    dac_host u_dac_host (.clk(clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus(bus));
    dac_card u_dac_card (.clk(clk), .rstn(rstn), .bus(bus),
        .twos_complement_select_jumper(jmp), .analog_out_ch0(out0),
        .analog_out_ch1(out1), .twos_format(twos_format));
    dac_link_chk u_dac_link_chk (.clk(clk), .rstn(rstn),
        .wr_stb(bus.wr_stb), .wide(bus.wide), .addr(bus.addr),
        .wdata(bus.wdata), .twos_complement_select_jumper(jmp),
        .analog_out_ch0(out0), .analog_out_ch1(out1),
        .twos_format(twos_format));
    // Clock and watchdog.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        test_done();
    end
    // Record every strobe seen on the link.
    always @(posedge clk) begin
        if (bus.wr_stb === 1'b1) stb_q.push_back({bus.wide, bus.addr,
            bus.wdata});
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task test_done();
        $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // One APB transfer, held until pready is seen.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task put_code(input int ch, input logic [11:0] v);
        stb_q.delete();
        apb(1'b1, ch ? REG_CH1_CODE : REG_CH0_CODE, {20'h0, v});
        repeat (6) @(posedge clk);
    endtask
    task t_reset();
        chk(out0, 32'h0);
        chk(out1, 32'h0);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(rd[1], 1'b0);
        $display("Reset test done");
    endtask
    task t_bytes();
        logic [11:0] v[4] = '{12'hABC, 12'h000, 12'hFFF, 12'h5A3};
        for (int i = 0; i < 8; i++) begin
            put_code(i % 2, v[i / 2]);
            code_exp[i % 2] = v[i / 2];
            chk(stb_q.size(), 2);
            chk(stb_q[0][20:16], 5'h8 + 5'(2 * (i % 2)));
            chk(stb_q[0][7:0], v[i / 2][7:0]);
            chk(stb_q[1][20:16], 5'h9 + 5'(2 * (i % 2)));
            chk(stb_q[1][7:0], {4'h0, v[i / 2][11:8]});
            chk(out0, code_exp[0]);
            chk(out1, code_exp[1]);
        end
        $display("Byte write test done");
    endtask
    task t_wide();
        apb(1'b1, REG_CTRL, 32'h1);
        put_code(0, 12'h7E1);
        chk(stb_q.size(), 1);
        chk(stb_q[0], {1'b1, 4'h8, 16'h07E1});
        chk(out0, 12'h7E1);
        apb(1'b1, REG_CTRL, 32'h0);
        $display("Wide write test done");
    endtask
    task t_twos();
        jmp <= 1'b1;
        apb(1'b1, REG_CTRL, 32'h2);
        repeat (5) @(posedge clk);
        chk(twos_format, 1'b1);
        put_code(1, 12'h800);
        chk(out1, 12'h800);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(rd[2:1], 2'b11);
        apb(1'b0, 8'h10, 32'h0);
        chk(er, 1'b1);
        $display("Coding test done");
    endtask
    // Main sequence.
    initial begin
        {rstn, psel, penable, pwrite, jmp} = 5'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        n_mismatch = 0;
        checks_done = 0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_bytes();
        t_wide();
        t_twos();
        test_done();
    end
endmodule
